/* File: logic/sie_pkg.sv */
`default_nettype none
package sie_pkg;
   // Register offsets on the local register port.
   localparam logic [7:0] ADDR_INT_EN = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;
   localparam logic [7:0] ADDR_SRC_FLAGS = 8'h32;
   localparam logic [7:0] ADDR_PIN_LEVEL = 8'h33;
   // Field positions of the enable register, shared by the source flags.
   localparam int BIT_WAKE_OUT = 0;
   localparam int BIT_BOOT_OFF = 1;
   localparam int BIT_AUTOSLEEP = 2;
   localparam int BIT_ORIENT = 3;
   localparam int BIT_CHG_IN = 4;
   localparam int BIT_CHG_OUT = 5;
   localparam int BIT_BUFFER = 6;
   localparam int BIT_SAMPLE = 7;
   // Source flags exist for bits 7 down to 2 only.
   localparam logic [7:0] SRC_MASK = 8'hFC;
   localparam logic [7:0] INT_EN_RESET_LOW = 8'h00;
   localparam logic [7:0] INT_EN_RESET_HIGH = 8'h20;
   // Timing of the pin pulses.
   localparam int CLK_MHZ = 100;
   localparam int MOTION_PULSE_MS = 5;
   localparam int MOTION_PULSE_CYCLES = MOTION_PULSE_MS * CLK_MHZ * 1000;
   localparam int BOOT_PULSE_MS = 1;
   localparam int BOOT_PULSE_CYCLES = BOOT_PULSE_MS * CLK_MHZ * 1000;
   localparam int PULSE_CNT_W = 20;
   // Sticky status bits of the controller's own interrupt.
   localparam int ST_W = 3;
   localparam int ST_MOTION = 0;
   localparam int ST_BOOT = 1;
   localparam int ST_OVERRUN = 2;
   // States of a pin pulse generator.
   typedef enum logic [0:0] {PG_IDLE = 1'b0, PG_ACTIVE = 1'b1} sie_pulse_state_t;
endpackage : sie_pkg
`default_nettype wire

/* File: logic/sie_pulse_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module sie_pulse_gen #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic abort,
   output logic active
);
   sie_pkg::sie_pulse_state_t state_q, state_d;
   logic [sie_pkg::PULSE_CNT_W-1:0] cnt_q, cnt_d;
   localparam logic [sie_pkg::PULSE_CNT_W-1:0] LAST = sie_pkg::PULSE_CNT_W'(WIDTH - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Next state: a start launches a pulse, abort or the last count ends it.
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         sie_pkg::PG_IDLE:
         begin
            cnt_d = '0;
            if (start && !abort)
               state_d = sie_pkg::PG_ACTIVE;
         end
         sie_pkg::PG_ACTIVE:
         begin
            cnt_d = cnt_q + 1'b1;
            if (abort || cnt_q == LAST)
            begin
               state_d = sie_pkg::PG_IDLE;
               cnt_d = '0;
            end
         end
         default:
            state_d = sie_pkg::PG_IDLE;
      endcase
   end

   // State registers.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= sie_pkg::PG_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   assign active = (state_q == sie_pkg::PG_ACTIVE);

   property p_pulse_end;
      @(posedge clk) disable iff (!reset_n)
      $fell(active) |-> $past(abort) || $past(cnt_q) == LAST;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("Pulse ended early.");

   property p_pulse_abort;
      @(posedge clk) disable iff (!reset_n)
      active && abort |=> !active;
   endproperty
   a_pulse_abort: assert property (p_pulse_abort) else $error("Abort ignored.");
endmodule : sie_pulse_gen
`default_nettype wire

/* File: logic/sie_irq_status.sv */
`timescale 1ns/1ns
`default_nettype none
module sie_irq_status (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [sie_pkg::ST_W-1:0] event_in,
   input wire logic clear_wr,
   input wire logic mask_wr,
   input wire logic [sie_pkg::ST_W-1:0] wdata,
   output logic [sie_pkg::ST_W-1:0] status,
   output logic [sie_pkg::ST_W-1:0] mask,
   output logic irq
);
   logic [sie_pkg::ST_W-1:0] status_q, status_d;
   logic [sie_pkg::ST_W-1:0] mask_q, mask_d;

   ////////////////////////////////////////////////////////////////////////////
   // Each bit is set by its event, cleared by writing one; the set wins.
   genvar i;
   generate
      for (i = 0; i < sie_pkg::ST_W; i++)
      begin : g_bit
         always_comb
         begin
            status_d[i] = event_in[i] | (status_q[i] & ~(clear_wr & wdata[i]));
         end
      end
   endgenerate

   // Mask register follows a write.
   always_comb
   begin
      mask_d = mask_wr ? wdata : mask_q;
   end

   // Status and mask registers.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status_q <= '0;
         mask_q <= '0;
      end
      else
      begin
         status_q <= status_d;
         mask_q <= mask_d;
      end
   end

   assign status = status_q;
   assign mask = mask_q;
   assign irq = |(status_q & mask_q);

   property p_irq_follows;
      @(posedge clk) disable iff (!reset_n)
      |(event_in & mask_q) && !mask_wr |=> irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("Unmasked event lost.");
endmodule : sie_irq_status
`default_nettype wire

/* File: logic/sie_top.sv */
// Overview of operation
// - Enable register at 0x20, one read/write bit per interrupt event generator.
// - Strap high: enabled interrupts with pin-select bit clear pulse motion pin low, open drain, motion width.
// - Strap high: pulse repeats each data-rate period while the source flag stays set.
// - Strap high: boot pin carries only boot-complete, active-low open-drain boot-width pulse.
// - Enable resets to zero; with strap high bit 5 resets to one.
// - Bit 7 enables data-ready interrupt onto the pin chosen by pin-select.
// - Strap low: reading output registers clears data-ready flag and its pin level.
// - Strap high: output read clears data-ready flag; pin pulse ends by itself.
// - Entering standby cuts a running data-ready pulse short.
// - Bit 6 routes the buffer interrupt to the selected pin; zero routes nowhere.
// - Bit 5 enables change-detector outside-threshold interrupt on selected pin.
// - Bit 4 enables change-detector inside-threshold interrupt on selected pin.
// - Bit 3 enables orientation-change interrupt on selected pin.
// - Bit 2 enables auto wake/sleep interrupt on selected pin.
// - Bit 1 set stops boot pulse routing; ignored with strap high.
// - Strap low: bit 0 holds selected pin active in wake, opposite level otherwise.
`timescale 1ns/1ns
`default_nettype none
module sie_top #(
   parameter int MOTION_PULSE_CYCLES = sie_pkg::MOTION_PULSE_CYCLES,
   parameter int BOOT_PULSE_CYCLES = sie_pkg::BOOT_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic boot_strap_select,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [7:0] src_event,
   input wire logic [7:0] src_clear,
   input wire logic data_reg_read,
   input wire logic boot_done_evt,
   input wire logic odr_tick,
   input wire logic [7:0] pin_select,
   input wire logic irq_polarity,
   input wire logic wake_state,
   input wire logic standby_mode,
   output logic [7:0] src_flags,
   input wire logic irq_pin_a_i,
   output logic irq_pin_a_o,
   output logic irq_pin_a_oe,
   input wire logic irq_pin_b_i,
   output logic irq_pin_b_o,
   output logic irq_pin_b_oe,
   output logic irq
);
   logic init_done_q, init_done_d;
   logic strap_q, strap_d;
   logic [7:0] en_q, en_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] rdata_q, rdata_d;
   logic pin_a_o_q, pin_a_o_d, pin_a_oe_q, pin_a_oe_d;
   logic pin_b_o_q, pin_b_o_d, pin_b_oe_q, pin_b_oe_d;
   logic [7:0] live;
   logic [7:0] routed_a, routed_b;
   logic [7:0] flag_clr;
   logic motion_start, motion_active;
   logic boot_start, boot_active;
   logic boot_on_b, wake_on_a, wake_on_b;
   logic act_a, act_b;
   logic wr_en, wr_clr, wr_mask;
   logic [sie_pkg::ST_W-1:0] st_event, st_status, st_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture and enable register; the strap is sampled once after reset.
   always_comb
   begin
      init_done_d = 1'b1;
      strap_d = strap_q;
      en_d = en_q;
      if (!init_done_q)
      begin
         strap_d = boot_strap_select;
         en_d = boot_strap_select ? sie_pkg::INT_EN_RESET_HIGH : sie_pkg::INT_EN_RESET_LOW;
      end
      else if (wr_en)
         en_d = wdata;
   end

   // Strap and enable registers.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         init_done_q <= 1'b0;
         strap_q <= 1'b0;
         en_q <= sie_pkg::INT_EN_RESET_LOW;
      end
      else
      begin
         init_done_q <= init_done_d;
         strap_q <= strap_d;
         en_q <= en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; writes are ignored during the strap capture cycle.
   assign wr_en = wr && init_done_q && addr == sie_pkg::ADDR_INT_EN;
   assign wr_clr = wr && init_done_q && addr == sie_pkg::ADDR_IRQ_STATUS;
   assign wr_mask = wr && init_done_q && addr == sie_pkg::ADDR_IRQ_MASK;

   // Source flags: a new event wins over a clear in the same cycle.
   always_comb
   begin
      flag_clr = src_clear;
      flag_clr[sie_pkg::BIT_SAMPLE] = src_clear[sie_pkg::BIT_SAMPLE] | data_reg_read;
      flags_d = ((flags_q & ~flag_clr) | src_event) & sie_pkg::SRC_MASK;
   end

   // Source flag register.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         flags_q <= '0;
      else
         flags_q <= flags_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // gate flags by enables
   assign live = en_q & flags_q & sie_pkg::SRC_MASK;
   assign routed_a = live & ~pin_select;
   assign routed_b = live & pin_select;

   assign motion_start = strap_q && init_done_q && odr_tick && (|routed_a);

   assign boot_start = boot_done_evt && init_done_q && (strap_q || !en_q[sie_pkg::BIT_BOOT_OFF]);

   // Motion pin pulse timer; standby aborts it.
   // self-ending data-ready pulse
   sie_pulse_gen #(
      .WIDTH(MOTION_PULSE_CYCLES)
   ) u_motion_pulse (
      .clk(clk),
      .reset_n(reset_n),
      .start(motion_start),
      .abort(standby_mode),
      .active(motion_active)
   );

   // Boot pin pulse timer.
   sie_pulse_gen #(
      .WIDTH(BOOT_PULSE_CYCLES)
   ) u_boot_pulse (
      .clk(clk),
      .reset_n(reset_n),
      .start(boot_start),
      .abort(1'b0),
      .active(boot_active)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Strap-low pin activity: wake output overrides other sources on its pin.
   assign boot_on_b = pin_select[sie_pkg::BIT_BOOT_OFF];
   assign wake_on_a = en_q[sie_pkg::BIT_WAKE_OUT] && !pin_select[sie_pkg::BIT_WAKE_OUT];
   assign wake_on_b = en_q[sie_pkg::BIT_WAKE_OUT] && pin_select[sie_pkg::BIT_WAKE_OUT];
   assign act_a = wake_on_a ? wake_state : ((|routed_a) || (boot_active && !boot_on_b));
   assign act_b = wake_on_b ? wake_state : ((|routed_b) || (boot_active && boot_on_b));

   // Pin drivers: push-pull with polarity in strap-low, open drain low pulses in strap-high.
   always_comb
   begin
      pin_a_o_d = irq_polarity ? act_a : ~act_a;
      pin_a_oe_d = init_done_q;
      pin_b_o_d = irq_polarity ? act_b : ~act_b;
      pin_b_oe_d = init_done_q;
      if (strap_q)
      begin
         pin_a_o_d = 1'b0;
         pin_a_oe_d = motion_active;
         pin_b_o_d = 1'b0;
         pin_b_oe_d = boot_active;
      end
   end

   // Pin output registers.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_a_o_q <= 1'b0;
         pin_a_oe_q <= 1'b0;
         pin_b_o_q <= 1'b0;
         pin_b_oe_q <= 1'b0;
      end
      else
      begin
         pin_a_o_q <= pin_a_o_d;
         pin_a_oe_q <= pin_a_oe_d;
         pin_b_o_q <= pin_b_o_d;
         pin_b_oe_q <= pin_b_oe_d;
      end
   end

   assign irq_pin_a_o = pin_a_o_q;
   assign irq_pin_a_oe = pin_a_oe_q;
   assign irq_pin_b_o = pin_b_o_q;
   assign irq_pin_b_oe = pin_b_oe_q;
   assign src_flags = flags_q;

   ////////////////////////////////////////////////////////////////////////////
   // Controller events: pulse launches and a source firing while still pending.
   always_comb
   begin
      st_event = '0;
      st_event[sie_pkg::ST_MOTION] = motion_start && !standby_mode && !motion_active;
      st_event[sie_pkg::ST_BOOT] = boot_start;
      st_event[sie_pkg::ST_OVERRUN] = |(src_event & flags_q & en_q & ~flag_clr);
   end

   sie_irq_status u_status (
      .clk(clk),
      .reset_n(reset_n),
      .event_in(st_event),
      .clear_wr(wr_clr),
      .mask_wr(wr_mask),
      .wdata(wdata[sie_pkg::ST_W-1:0]),
      .status(st_status),
      .mask(st_mask),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid the cycle after the read strobe; unmapped reads give zero.
   always_comb
   begin
      rdata_d = '0;
      if (rd)
      begin
         case (addr)
            sie_pkg::ADDR_INT_EN: rdata_d = en_q;
            sie_pkg::ADDR_IRQ_STATUS: rdata_d = 8'(st_status);
            sie_pkg::ADDR_IRQ_MASK: rdata_d = 8'(st_mask);
            sie_pkg::ADDR_SRC_FLAGS: rdata_d = flags_q;
            sie_pkg::ADDR_PIN_LEVEL: rdata_d = {6'h00, irq_pin_b_i, irq_pin_a_i};
            default: rdata_d = '0;
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_q <= '0;
      else
         rdata_q <= rdata_d;
   end

   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   property p_en_reset;
      @(posedge clk) disable iff (!reset_n)
      $rose(init_done_q) |-> en_q == (strap_q ? sie_pkg::INT_EN_RESET_HIGH : sie_pkg::INT_EN_RESET_LOW);
   endproperty
   a_en_reset: assert property (p_en_reset) else $error("Enable reset value wrong.");

   property p_en_read;
      @(posedge clk) disable iff (!reset_n)
      rd && addr == sie_pkg::ADDR_INT_EN |=> rdata == $past(en_q);
   endproperty
   a_en_read: assert property (p_en_read) else $error("Enable readback wrong.");

   property p_sample_clear;
      @(posedge clk) disable iff (!reset_n)
      data_reg_read && !src_event[sie_pkg::BIT_SAMPLE] |=> !flags_q[sie_pkg::BIT_SAMPLE];
   endproperty
   a_sample_clear: assert property (p_sample_clear) else $error("Data-ready not cleared.");

   property p_repeat;
      @(posedge clk) disable iff (!reset_n)
      motion_start && !standby_mode && !motion_active |=> motion_active;
   endproperty
   a_repeat: assert property (p_repeat) else $error("Pending source gave no pulse.");

   property p_open_drain;
      @(posedge clk) disable iff (!reset_n)
      strap_q && pin_a_oe_q |-> !pin_a_o_q && $past(motion_active);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("Motion pin not low pulse.");

   property p_boot_only;
      @(posedge clk) disable iff (!reset_n)
      strap_q && init_done_q && !boot_active |=> !pin_b_oe_q;
   endproperty
   a_boot_only: assert property (p_boot_only) else $error("Boot pin driven without boot.");

   property p_gate;
      @(posedge clk) disable iff (!reset_n)
      !strap_q && init_done_q && !(|routed_a) && !boot_active && !wake_on_a
         |=> pin_a_o_q == !$past(irq_polarity);
   endproperty
   a_gate: assert property (p_gate) else $error("Pin asserted without enabled flag.");
endmodule : sie_top
`default_nettype wire

/* File: testbench/sie_host_pins.sv */
`timescale 1ns/1ns
`default_nettype none
// Host side of both interrupt lines: the external pull-ups and the level that the host sees.
module sie_host_pins (
   input wire logic a_o,
   input wire logic a_oe,
   input wire logic b_o,
   input wire logic b_oe,
   output logic pin_a,
   output logic pin_b
);
   ////////////////////////////////////////////////////////////////
   // motion pin pull-up
   // A released line is pulled up to the supply, so it reads high whenever its driver is off.
   assign pin_a = a_oe ? a_o : 1'b1;
   // boot pin pull-up
   // The boot line has the same pull-up.
   assign pin_b = b_oe ? b_o : 1'b1;
endmodule : sie_host_pins
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int MP = 20;
   localparam int BP = 10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic strap = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] src_event = 8'h00;
   logic [7:0] src_clear = 8'h00;
   logic drd = 1'b0;
   logic boot_evt = 1'b0;
   logic tick = 1'b0;
   logic [7:0] psel = 8'h00;
   logic pol = 1'b1;
   logic wake = 1'b0;
   logic stby = 1'b0;
   logic [7:0] rdata, flags;
   logic a_o, a_oe, b_o, b_oe, pin_a, pin_b, irq;
   int n_errors = 0;
   int total_checks = 0;
   int cyc_cnt = 0;
   logic [7:0] en, d, exp_pins;
   int b, w;

   ////////////////////////////////////////////////////////////////
   // Clock, design under test and the host side of the pins.
   always #5 clk = ~clk;

   sie_top #(.MOTION_PULSE_CYCLES(MP), .BOOT_PULSE_CYCLES(BP)) uut (.clk(clk), .reset_n(reset_n),
      .boot_strap_select(strap), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .src_event(src_event), .src_clear(src_clear), .data_reg_read(drd), .boot_done_evt(boot_evt),
      .odr_tick(tick), .pin_select(psel), .irq_polarity(pol), .wake_state(wake), .standby_mode(stby),
      .src_flags(flags), .irq_pin_a_i(pin_a), .irq_pin_a_o(a_o), .irq_pin_a_oe(a_oe),
      .irq_pin_b_i(pin_b), .irq_pin_b_o(b_o), .irq_pin_b_oe(b_oe), .irq(irq));

   sie_host_pins host (.a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .pin_a(pin_a), .pin_b(pin_b));

   ////////////////////////////////////////////////////////////////
   // Verdict and hang guard.
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   // Cuts a hung run short well beyond the expected length.
   always @(posedge clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         n_errors++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////
   // Comparison, bus and stimulus tasks.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rreg

   // One-cycle pulse on the event, clear, tick, output-read and boot inputs together.
   task automatic pulse(input logic [7:0] ev, input logic [7:0] cl, input logic t, input logic r,
                        input logic bt);
      @(posedge clk);
      src_event <= ev;
      src_clear <= cl;
      tick <= t;
      drd <= r;
      boot_evt <= bt;
      @(posedge clk);
      src_event <= 8'h00;
      src_clear <= 8'h00;
      tick <= 1'b0;
      drd <= 1'b0;
      boot_evt <= 1'b0;
   endtask : pulse

   // Counts the cycles a pin stays low; zero when no pulse starts within eight cycles.
   task automatic width(input bit on_b, output int n);
      int i;
      n = 0;
      for (i = 0; i < 8 && (on_b ? pin_b : pin_a) !== 1'b0; i++)
         @(negedge clk);
      while ((on_b ? pin_b : pin_a) === 1'b0 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
   endtask : width

   task automatic do_reset(input logic s);
      @(posedge clk);
      reset_n <= 1'b0;
      strap <= s;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   // Pin level for an active or inactive state under the given polarity.
   function automatic logic lvl(input logic act, input logic p);
      return act ? p : ~p;
   endfunction : lvl

   ////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      void'($urandom(32'h0DA0BCD8));
      do_reset(1'b0);
      rreg(sie_pkg::ADDR_INT_EN, d);
      check(d, 8'h00);
      rreg(8'h7E, d);
      check(d, 8'h00);
      wreg(sie_pkg::ADDR_SRC_FLAGS, 8'hFF);
      rreg(sie_pkg::ADDR_SRC_FLAGS, d);
      check(d, 8'h00);
      repeat (4)
      begin
         en = 8'($urandom());
         wreg(sie_pkg::ADDR_INT_EN, en);
         rreg(sie_pkg::ADDR_INT_EN, d);
         check(d, en);
      end
      $display("register test done");
      // Each source routed, cleared, then disabled, on a random pin and polarity.
      for (b = 2; b < 8; b++)
      begin
         en = 8'h01 << b;
         @(posedge clk);
         psel <= 8'($urandom());
         pol <= 1'($urandom());
         wreg(sie_pkg::ADDR_INT_EN, en);
         pulse(en, 8'h00, 1'b0, 1'b0, 1'b0);
         repeat (3) @(negedge clk);
         check(flags & en, en);
         exp_pins = psel[b] ? {6'h00, lvl(1'b1, pol), lvl(1'b0, pol)} : {6'h00, lvl(1'b0, pol), lvl(1'b1, pol)};
         check({6'h00, pin_b, pin_a}, exp_pins);
         pulse(8'h00, (b == 7) ? 8'h00 : en, 1'b0, b == 7, 1'b0);
         repeat (3) @(negedge clk);
         check(flags & en, 8'h00);
         check({6'h00, pin_b, pin_a}, {6'h00, lvl(1'b0, pol), lvl(1'b0, pol)});
         wreg(sie_pkg::ADDR_INT_EN, 8'h00);
         pulse(en, 8'h00, 1'b0, 1'b0, 1'b0);
         repeat (3) @(negedge clk);
         check({pin_b, pin_a}, {lvl(1'b0, pol), lvl(1'b0, pol)});
         pulse(8'h00, en, 1'b0, 1'b0, 1'b0);
      end
      $display("routing test done");
      @(posedge clk);
      psel <= 8'h00;
      pol <= 1'b1;
      wreg(sie_pkg::ADDR_INT_EN, 8'h01);
      @(posedge clk);
      wake <= 1'b1;
      repeat (3) @(negedge clk);
      check(pin_a, 1'b1);
      rreg(sie_pkg::ADDR_PIN_LEVEL, d);
      check(d, 8'h01);
      @(posedge clk);
      wake <= 1'b0;
      repeat (3) @(negedge clk);
      check(pin_a, 1'b0);
      // Boot pulse, active low, on pin b, and the status, mask and clear path.
      @(posedge clk);
      pol <= 1'b0;
      psel <= 8'h02;
      wreg(sie_pkg::ADDR_INT_EN, 8'h00);
      wreg(sie_pkg::ADDR_IRQ_STATUS, 8'h07);
      wreg(sie_pkg::ADDR_IRQ_MASK, 8'h00);
      pulse(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
      width(1'b1, w);
      check(w[7:0], 8'(BP));
      check(irq, 1'b0);
      wreg(sie_pkg::ADDR_IRQ_MASK, 8'h02);
      @(negedge clk);
      check(irq, 1'b1);
      rreg(sie_pkg::ADDR_IRQ_STATUS, d);
      check(d & 8'h02, 8'h02);
      wreg(sie_pkg::ADDR_IRQ_STATUS, 8'h02);
      @(negedge clk);
      check(irq, 1'b0);
      wreg(sie_pkg::ADDR_INT_EN, 8'h02);
      pulse(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
      width(1'b1, w);
      check(w[7:0], 8'h00);
      $display("strap low test done");
      // Strap high: repeated motion pulses, standby abort, unrouting, data-ready, boot pin.
      @(posedge clk);
      psel <= 8'h00;
      do_reset(1'b1);
      rreg(sie_pkg::ADDR_INT_EN, d);
      check(d, 8'h20);
      pulse(8'h20, 8'h00, 1'b0, 1'b0, 1'b0);
      repeat (2)
      begin
         pulse(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
         width(1'b0, w);
         check(w[7:0], 8'(MP));
      end
      pulse(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
      repeat (6) @(posedge clk);
      stby <= 1'b1;
      width(1'b0, w);
      check(8'(w <= 4), 8'h01);
      @(posedge clk);
      stby <= 1'b0;
      psel <= 8'h20;
      pulse(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
      width(1'b0, w);
      check(w[7:0], 8'h00);
      width(1'b1, w);
      check(w[7:0], 8'h00);
      @(posedge clk);
      psel <= 8'h00;
      pulse(8'h00, 8'h20, 1'b0, 1'b0, 1'b0);
      pulse(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
      width(1'b0, w);
      check(w[7:0], 8'h00);
      wreg(sie_pkg::ADDR_INT_EN, 8'h82);
      pulse(8'h80, 8'h00, 1'b0, 1'b0, 1'b0);
      pulse(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
      repeat (2) @(negedge clk);
      check(flags[7], 1'b0);
      width(1'b0, w);
      check(w[7:0], 8'(MP));
      pulse(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
      width(1'b1, w);
      check(w[7:0], 8'(BP));
      rreg(sie_pkg::ADDR_IRQ_STATUS, d);
      check(d, 8'h03);
      $display("strap high test done");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
